// ===== core/valley_skip_switch_on_control.sv
// Switch-on control: start-up, soft-start, valley skipping, overvoltage latch
//
// Overview of operation
// - Above supply-on threshold: stop charger, start
// - Soft-start lasts 12ms in four steps
// - Sense limit rises 0.32V to 1V
// - Turn-on digital, turn-off from analog comparator
// - Skip counter holds crossings counted before turn-on
// - Sample feedback zones every 48ms period
// - Always below low zone: count up, max 7
// - Between low and high zones: hold
// - Once above high zone: count down, min 1
// - Above reset-to-one threshold: load 1
// - Skip counter saturates between 1 and 7
// - Skip counter starts at 1
// - Zone thresholds follow line voltage level
// - Crossing counter saturates between 0 and 7
// - Falling 100mV crossing after turn-off increments
// - Crossing counter clears when gate rises
// - Off-time overvoltage latches off after blanking
// - After suppression, turn on when count reached
// - No turn-on during ringing suppression
// - Maximum off-time forces turn-on
`timescale 1ns/10ps
module valley_skip_switch_on_control
  import valley_pkg::*;
#(
  parameter int SOFT_STEP_LEN = SOFT_STEP_CYCLES,
  parameter int PERIOD_LEN = COUNTER_PERIOD_CYCLES,
  parameter int RING_LONG_LEN = RING_LONG_CYCLES,
  parameter int RING_SHORT_LEN = RING_SHORT_CYCLES,
  parameter int MAX_OFF_LEN = MAX_OFF_CYCLES,
  parameter int OVP_BLANK_LEN = OVP_BLANK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supplyAboveOn,
  input wire logic zeroCrossingAbove,
  input wire logic zeroCrossingAboveRing,
  input wire logic zeroCrossingOvervoltage,
  input wire logic feedbackAboveLowZone,
  input wire logic feedbackAboveHighZone,
  input wire logic feedbackAboveResetOne,
  input wire logic senseTripOff,
  output logic gateOutputA,
  output logic startupCellEnable,
  output logic [valley_pkg::LIMIT_W-1:0] senseLimitMv,
  output logic [2:0] skipCountOut,
  output logic latchedOff
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_CHARGE = 4'b0001,
    ST_SOFT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_LATCH = 4'b1000
  } mode_e;

  mode_e mode;
  mode_e next_mode;
  logic [31:0] stepTimer;
  logic [31:0] next_stepTimer;
  logic [1:0] stepIndex;
  logic [1:0] next_stepIndex;
  logic [31:0] periodTimer;
  logic [31:0] next_periodTimer;
  logic [31:0] offTimer;
  logic [31:0] next_offTimer;
  logic [31:0] ovpTimer;
  logic [31:0] next_ovpTimer;
  logic next_gate;
  logic next_startupCell;
  logic [LIMIT_W-1:0] next_limit;
  logic running;
  logic periodTick;
  logic [2:0] zcCount;
  logic ringLong;
  logic next_ringLong;
  logic ringDone;
  logic offExpired;
  logic countReached;

  zone_if zone ();

  ////////////////////////////////////////////////////////////////////////////
  // Zone comparators are trimmed to line voltage outside this block
  assign zone.aboveLow = feedbackAboveLowZone;
  assign zone.aboveHigh = feedbackAboveHighZone;
  assign zone.aboveResetOne = feedbackAboveResetOne;
  assign zone.periodTick = periodTick;
  assign running = (mode == ST_SOFT) || (mode == ST_RUN);

  updown_counter skipCounter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .running(running),
    .zone(zone)
  );

  zc_counter crossingCounter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(next_gate && !gateOutputA),
    .countEn(running && !gateOutputA),
    .zcLevel(zeroCrossingAbove),
    .count(zcCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Off-time decisions
  assign ringDone = ringLong ? (offTimer >= 32'(RING_LONG_LEN))
                             : (offTimer >= 32'(RING_SHORT_LEN));
  assign offExpired = offTimer >= 32'(MAX_OFF_LEN - 1);
  assign countReached = zcCount >= zone.skipCount;
  assign periodTick = running && (periodTimer == 32'(PERIOD_LEN - 1));

  // Mode sequencing, soft-start and timers
  always_comb
  begin
    next_mode = mode;
    next_stepTimer = stepTimer;
    next_stepIndex = stepIndex;
    next_periodTimer = running ? periodTimer + 32'h1 : 32'h0;
    next_offTimer = gateOutputA ? 32'h0 : offTimer + 32'h1;
    next_ovpTimer = 32'h0;
    next_ringLong = ringLong;
    next_gate = gateOutputA;
    next_startupCell = startupCellEnable;
    next_limit = senseLimitMv;
    if (periodTick)
      next_periodTimer = 32'h0;
    case (mode)
      ST_CHARGE:
      begin
        next_gate = 1'b0;
        next_limit = LIMIT_ZERO;
        next_startupCell = 1'b1;
        if (supplyAboveOn)
        begin
          next_mode = ST_SOFT;
          next_startupCell = 1'b0;
          next_stepTimer = 32'h0;
          next_stepIndex = 2'h0;
          next_limit = LIMIT_START_MV;
        end
      end
      ST_SOFT, ST_RUN:
      begin
        if (mode == ST_SOFT)
        begin
          next_stepTimer = stepTimer + 32'h1;
          if (stepTimer == 32'(SOFT_STEP_LEN - 1))
          begin
            next_stepTimer = 32'h0;
            if (stepIndex == 2'(SOFT_START_STEPS - 1))
            begin
              next_mode = ST_RUN;
              next_limit = LIMIT_FINAL_MV;
            end
            else
            begin
              next_stepIndex = stepIndex + 2'h1;
              // Equal increments, the last step end lands on the final level
              next_limit = senseLimitMv + LIMIT_STEP_MV;
            end
          end
        end
        if (gateOutputA)
        begin
          if (senseTripOff)
          begin
            next_gate = 1'b0;
            next_ringLong = 1'b1;
          end
        end
        else
        begin
          // Ringing level picks long or short suppression
          if (offTimer == 32'h0)
            next_ringLong = !zeroCrossingAboveRing;
          if ((ringDone && countReached) || offExpired)
            next_gate = 1'b1;
          if (zeroCrossingOvervoltage)
          begin
            next_ovpTimer = ovpTimer + 32'h1;
            if (ovpTimer >= 32'(OVP_BLANK_LEN - 1))
            begin
              next_mode = ST_LATCH;
              next_gate = 1'b0;
            end
          end
        end
      end
      ST_LATCH:
      begin
        next_gate = 1'b0;
        next_limit = LIMIT_ZERO;
      end
      default:
      begin
        next_mode = ST_CHARGE;
        next_gate = 1'b0;
      end
    endcase
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= ST_CHARGE;
      stepTimer <= 32'h0;
      stepIndex <= 2'h0;
      periodTimer <= 32'h0;
      offTimer <= 32'h0;
      ovpTimer <= 32'h0;
      ringLong <= 1'b1;
      gateOutputA <= 1'b0;
      startupCellEnable <= 1'b1;
      senseLimitMv <= LIMIT_ZERO;
      skipCountOut <= UPDOWN_RESET;
      latchedOff <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      stepTimer <= next_stepTimer;
      stepIndex <= next_stepIndex;
      periodTimer <= next_periodTimer;
      offTimer <= next_offTimer;
      ovpTimer <= next_ovpTimer;
      ringLong <= next_ringLong;
      gateOutputA <= next_gate;
      startupCellEnable <= next_startupCell;
      senseLimitMv <= next_limit;
      skipCountOut <= zone.skipCount;
      latchedOff <= (next_mode == ST_LATCH);
    end
  end
endmodule

// ===== core/valley_pkg.sv
// Constants shared by the valley-skip switch-on control
package valley_pkg;
  localparam int CLK_FREQ_HZ = 200000000;
  // Soft-start timing
  localparam int SOFT_START_TIME_MS = 12;
  localparam int SOFT_START_STEPS = 4;
  localparam longint SOFT_START_CYCLES = longint'(SOFT_START_TIME_MS) * CLK_FREQ_HZ / 1000;
  localparam int SOFT_STEP_CYCLES = int'(SOFT_START_CYCLES / SOFT_START_STEPS);
  // Counter sampling period
  localparam int COUNTER_PERIOD_MS = 48;
  localparam int COUNTER_PERIOD_CYCLES = int'(longint'(COUNTER_PERIOD_MS) * CLK_FREQ_HZ / 1000);
  // Off-time timing defaults (not documented, plain values)
  localparam int RING_LONG_US = 5;
  localparam int RING_LONG_CYCLES = RING_LONG_US * (CLK_FREQ_HZ / 1000000);
  localparam int RING_SHORT_US = 2;
  localparam int RING_SHORT_CYCLES = RING_SHORT_US * (CLK_FREQ_HZ / 1000000);
  localparam int MAX_OFF_US = 50;
  localparam int MAX_OFF_CYCLES = MAX_OFF_US * (CLK_FREQ_HZ / 1000000);
  localparam int OVP_BLANK_US = 1;
  localparam int OVP_BLANK_CYCLES = OVP_BLANK_US * (CLK_FREQ_HZ / 1000000);
  // Counter ranges
  localparam logic [2:0] UPDOWN_MIN = 3'h1;
  localparam logic [2:0] UPDOWN_MAX = 3'h7;
  localparam logic [2:0] UPDOWN_RESET = 3'h1;
  localparam logic [2:0] ZC_MAX = 3'h7;
  localparam logic [2:0] ZC_RESET = 3'h0;
  // Current-sense limit code: 0.32V..1V in millivolts
  localparam int LIMIT_W = 10;
  localparam logic [9:0] LIMIT_START_MV = 10'h140;
  localparam logic [9:0] LIMIT_FINAL_MV = 10'h3e8;
  localparam logic [9:0] LIMIT_STEP_MV = 10'h0aa;
  localparam logic [9:0] LIMIT_ZERO = 10'h000;
endpackage

// ===== core/zone_if.sv
// Interface carrying feedback zone levels and the counter update strobe
`timescale 1ns/10ps
interface zone_if;
  logic aboveLow;
  logic aboveHigh;
  logic aboveResetOne;
  logic periodTick;
  logic [2:0] skipCount;
  modport source (output aboveLow, output aboveHigh, output aboveResetOne,
                  output periodTick, input skipCount);
  modport counter (input aboveLow, input aboveHigh, input aboveResetOne,
                   input periodTick, output skipCount);
endinterface

// ===== core/updown_counter.sv
// Saturating 1..7 skip counter with per-period feedback zone latches
`timescale 1ns/10ps
module updown_counter
  import valley_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic running,
  zone_if.counter zone
);
  logic sawLow;
  logic sawHigh;
  logic [2:0] count;
  logic next_sawLow;
  logic next_sawHigh;
  logic [2:0] next_count;

  assign zone.skipCount = count;

  // Zone observation and counter update
  always_comb
  begin
    next_sawLow = sawLow | zone.aboveLow;
    next_sawHigh = sawHigh | zone.aboveHigh;
    next_count = count;
    if (!running)
    begin
      next_count = UPDOWN_RESET;
      next_sawLow = 1'b0;
      next_sawHigh = 1'b0;
    end
    else
    begin
      if (zone.aboveResetOne)
        next_count = UPDOWN_MIN;
      else if (zone.periodTick)
      begin
        if (!sawLow && count != UPDOWN_MAX)
          next_count = count + 3'h1;
        else if (sawHigh && count != UPDOWN_MIN)
          next_count = count - 3'h1;
        // Otherwise hold
      end
      // Latches restart every period, even when a load to one wins
      if (zone.periodTick)
      begin
        next_sawLow = zone.aboveLow;
        next_sawHigh = zone.aboveHigh;
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sawLow <= 1'b0;
      sawHigh <= 1'b0;
      count <= UPDOWN_RESET;
    end
    else
    begin
      sawLow <= next_sawLow;
      sawHigh <= next_sawHigh;
      count <= next_count;
    end
  end
endmodule

// ===== core/zc_counter.sv
// Saturating 0..7 zero-crossing counter
`timescale 1ns/10ps
module zc_counter
  import valley_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic countEn,
  input wire logic zcLevel,
  output logic [2:0] count
);
  logic zcPrev;
  logic [2:0] next_count;

  // Falling edge of the comparator counts, gate high clears
  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = ZC_RESET;
    else if (countEn && zcPrev && !zcLevel && count != ZC_MAX)
      next_count = count + 3'h1;
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zcPrev <= 1'b0;
      count <= ZC_RESET;
    end
    else
    begin
      zcPrev <= zcLevel;
      count <= next_count;
    end
  end
endmodule

// ===== sim/valley_chk.sv
// Assertions on the switch-on control ports
`timescale 1ns/10ps
module valley_chk
  import valley_pkg::*;
#(
  parameter int SOFT_STEP_LEN = 20,
  parameter int MAX_OFF_LEN = 40
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supplyAboveOn,
  input wire logic zeroCrossingAbove,
  input wire logic zeroCrossingAboveRing,
  input wire logic zeroCrossingOvervoltage,
  input wire logic feedbackAboveLowZone,
  input wire logic feedbackAboveHighZone,
  input wire logic feedbackAboveResetOne,
  input wire logic senseTripOff,
  input wire logic gateOutputA,
  input wire logic startupCellEnable,
  input wire logic [valley_pkg::LIMIT_W-1:0] senseLimitMv,
  input wire logic [2:0] skipCountOut,
  input wire logic latchedOff
);
  localparam int STEP_M1 = SOFT_STEP_LEN - 1;
  localparam int OFF_HI = MAX_OFF_LEN + 2;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Start-up and soft-start
  a_idle_charge: assert property (startupCellEnable |-> !gateOutputA && senseLimitMv == 10'h000)
    else $error("switching while charging");
  a_first_limit: assert property ($fell(startupCellEnable) |-> $past(supplyAboveOn) && senseLimitMv == LIMIT_START_MV)
    else $error("bad start of soft-start");
  a_step_time: assert property ($fell(startupCellEnable) |-> ##STEP_M1 senseLimitMv == 10'h140 ##1 senseLimitMv == 10'h1ea)
    else $error("soft-start step timing off");
  ////////////////////////////////////////////////////////////
  // Skip counter
  a_reset_one: assert property (feedbackAboveResetOne |-> ##2 skipCountOut == UPDOWN_RESET)
    else $error("skip count not loaded with one");
  a_skip_step: assert property ($changed(skipCountOut) |-> skipCountOut != 3'h0 && (skipCountOut == 3'h1 || skipCountOut == $past(skipCountOut) + 3'h1 || skipCountOut == $past(skipCountOut) - 3'h1))
    else $error("skip count jumped");
  ////////////////////////////////////////////////////////////
  // Off time and latch
  a_ring_hold: assert property ($fell(gateOutputA) |-> !gateOutputA [*2])
    else $error("gate back on during suppression");
  a_max_off: assert property ($fell(gateOutputA) |-> ##[1:OFF_HI] (gateOutputA || latchedOff))
    else $error("off time too long");
  a_ovp_blank: assert property ($rose(latchedOff) |-> $past(zeroCrossingOvervoltage, 2))
    else $error("latch without blanked overvoltage");
  a_latch_hold: assert property (latchedOff |=> latchedOff && !gateOutputA)
    else $error("latch released or gate on");
  // Main scenarios reached
  c_start: cover property ($fell(startupCellEnable));
  c_full: cover property (skipCountOut == UPDOWN_MAX);
  c_latch: cover property ($rose(latchedOff));
endmodule

// ===== sim/flyback_model.sv
// Behavioural auxiliary winding and sense network
`timescale 1ns/10ps
module flyback_model (
  input wire logic sys_clk,
  input wire logic gateOutputA,
  input wire logic [3:0] rings,
  output logic senseTripOff,
  output logic zeroCrossingAbove
);
  int onTime;
  int offTime;
  bit [3:0] left;
  ////////////////////////////////////////////////////////////
  // Time since the last gate edge; ring count taken while on
  always_ff @(posedge sys_clk)
  begin
    onTime <= gateOutputA ? onTime + 1 : 0;
    offTime <= gateOutputA ? 0 : offTime + 1;
    if (gateOutputA)
      left <= rings;
  end
  // Current ramp trips the comparator in the fourth on cycle
  assign senseTripOff = gateOutputA && onTime >= 3;
  // Decaying ring: one falling crossing every four cycles, then low
  assign zeroCrossingAbove = !gateOutputA && offTime < 4 * left && offTime % 4 < 2;
endmodule

// ===== sim/tb.sv
// Self-checking bench for the switch-on control
`timescale 1ns/10ps
module tb;
  import valley_pkg::*;
  logic sys_clk, rst_n, supplyAboveOn, zcRing, zcOvp, fbLow, fbHigh, fbOne;
  logic zcAbove, tripOff, gateOutputA, startupCellEnable, latchedOff;
  logic [9:0] senseLimitMv;
  logic [2:0] skipCountOut;
  logic [3:0] rings;
  int failures, n_tests;
  ////////////////////////////////////////////////////////////
  // Block under test with shortened counts, and its far side
  valley_skip_switch_on_control #(.SOFT_STEP_LEN(20), .PERIOD_LEN(50), .RING_LONG_LEN(5),
    .RING_SHORT_LEN(2), .MAX_OFF_LEN(40), .OVP_BLANK_LEN(3)) valley_skip_switch_on_control_inst (
    .sys_clk, .rst_n, .supplyAboveOn, .zeroCrossingAbove(zcAbove), .zeroCrossingAboveRing(zcRing),
    .zeroCrossingOvervoltage(zcOvp), .feedbackAboveLowZone(fbLow), .feedbackAboveHighZone(fbHigh),
    .feedbackAboveResetOne(fbOne), .senseTripOff(tripOff), .gateOutputA, .startupCellEnable,
    .senseLimitMv, .skipCountOut, .latchedOff);
  flyback_model flyback_model_inst (.sys_clk, .gateOutputA, .rings,
    .senseTripOff(tripOff), .zeroCrossingAbove(zcAbove));
  ////////////////////////////////////////////////////////////
  // Helpers
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task checkVal(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task checkTime(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask
  function automatic logic [9:0] probe(input int sel);
    return sel == 0 ? senseLimitMv : sel == 1 ? 10'(skipCountOut) : 10'(gateOutputA);
  endfunction
  // Bounded wait for an output to move; n is the cycles taken
  task waitChange(input int sel, input int lim, output int n);
    logic [9:0] old;
    old = probe(sel);
    n = 0;
    while (probe(sel) === old)
    begin
      tick(1);
      n++;
      if (n > lim)
      begin
        failures++;
        stop_test();
      end
    end
  endtask
  task waitFall;
    int n;
    if (gateOutputA === 1'b0)
      waitChange(2, 60, n);
    waitChange(2, 60, n);
  endtask
  task measureOff(input logic [3:0] crossings, input int lo, input int hi);
    int n;
    rings = crossings;
    waitFall();
    waitChange(2, 60, n);
    checkTime("off time", lo, hi, n);
  endtask
  ////////////////////////////////////////////////////////////
  // Scenarios
  task testStartup;
    int n, total;
    logic [9:0] steps [4];
    steps = '{10'h1ea, 10'h294, 10'h33e, 10'h3e8};
    checkVal("skip", 10'h1, skipCountOut);
    tick(5);
    checkVal("cell", 10'h1, startupCellEnable);
    supplyAboveOn = 1'b1;
    waitChange(0, 5, n);
    checkVal("cell", 10'h0, startupCellEnable);
    checkVal("limit", LIMIT_START_MV, senseLimitMv);
    total = 0;
    foreach (steps[i])
    begin
      waitChange(0, 25, n);
      total += n;
      checkVal("limit", steps[i], senseLimitMv);
    end
    checkTime("soft-start", 80, 80, total);
    $display("startup test done");
  endtask
  task testSkip;
    int n;
    fbLow = 1'b0;
    repeat (3) waitChange(1, 110, n);
    checkVal("skip", 10'h4, skipCountOut);
    fbLow = 1'b1;
    tick(110);
    checkVal("skip", 10'h4, skipCountOut);
    fbLow = 1'b0;
    repeat (3) waitChange(1, 110, n);
    tick(110);
    checkVal("skip", 10'h7, skipCountOut);
    measureOff(4'h4, 40, 40);
    measureOff(4'h4, 40, 40);
    measureOff(4'h8, 28, 28);
    {fbLow, fbHigh} = 2'h3;
    waitChange(1, 110, n);
    checkVal("skip", 10'h6, skipCountOut);
    fbOne = 1'b1;
    tick(1);
    fbOne = 1'b0;
    tick(3);
    checkVal("skip", 10'h1, skipCountOut);
    tick(110);
    checkVal("skip", 10'h1, skipCountOut);
    measureOff(4'h2, 6, 6);
    zcRing = 1'b1;
    measureOff(4'h2, 4, 4);
    zcRing = 1'b0;
    $display("skip counter test done");
  endtask
  task testOvp;
    waitFall();
    zcOvp = 1'b1;
    tick(2);
    zcOvp = 1'b0;
    tick(8);
    checkVal("latch", 10'h0, latchedOff);
    waitFall();
    zcOvp = 1'b1;
    tick(3);
    zcOvp = 1'b0;
    checkVal("latch", 10'h1, latchedOff);
    tick(50);
    checkVal("gate", 10'h0, gateOutputA);
    $display("overvoltage test done");
  endtask
  ////////////////////////////////////////////////////////////
  // Clock, reset and sequence
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rst_n, supplyAboveOn, zcOvp} = 3'h0;
    {zcRing, fbHigh, fbOne} = 3'h0;
    fbLow = 1'b1;
    rings = 4'h2;
    failures = 0;
    n_tests = 0;
    tick(3);
    rst_n = 1'b1;
    tick(1);
    testStartup();
    testSkip();
    testOvp();
    stop_test();
  end
endmodule
bind valley_skip_switch_on_control valley_chk #(.SOFT_STEP_LEN(SOFT_STEP_LEN),
  .MAX_OFF_LEN(MAX_OFF_LEN)) valley_chk_inst (.*);
